//--- inc/interval_timer_pkg.sv
// Constants, register map and timing counts for the programmable interval timer
//
// Overview of operation
// - Eight preset lines form an 8-bit count, line 0 least significant.
// - After load, count decrements once per tick of the selected clock.
// - At zero the active-low zero output goes low, signalling the host.
// - Four decade stages divide the 1 MHz phase clock to 100k, 10k, 1k, 100 Hz.
// - An eight-way selector passes undivided, one decade output, or ground.
// - Codes 001..101 select 100 Hz, 1 kHz, 10 kHz, 100 kHz, 1 MHz.
// - Codes 000, 110, 111 select ground, so the timer stops.
// - Select bit 3 high gates off every counter clock.
package interval_timer_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] rate_select_addr   = 8'h00;
    localparam logic [7:0] preset_count_addr  = 8'h04;
    localparam logic [7:0] count_status_addr  = 8'h08;
    localparam logic [7:0] irq_status_addr    = 8'h0C;
    localparam logic [7:0] irq_mask_addr      = 8'h10;

    // ==========================================================
    // Field positions and reset values
    localparam int         disable_bit        = 3;
    localparam int         zero_bit           = 8;
    localparam int         irq_zero_bit       = 0;
    localparam int         irq_load_bit       = 1;
    localparam logic [3:0] rate_select_reset  = 4'h0;
    localparam logic [7:0] preset_count_reset = 8'h00;
    localparam logic [1:0] irq_mask_reset     = 2'h0;

    // ==========================================================
    // Rate codes
    localparam logic [2:0] rate_100hz  = 3'h1;
    localparam logic [2:0] rate_1khz   = 3'h2;
    localparam logic [2:0] rate_10khz  = 3'h3;
    localparam logic [2:0] rate_100khz = 3'h4;
    localparam logic [2:0] rate_1mhz   = 3'h5;

    // ==========================================================
    // Timing
    localparam int         clock_hz          = 10_000_000;
    localparam int         phase_hz          = 1_000_000;
    localparam int         phase_div_cycles  = clock_hz / phase_hz;
    localparam logic [3:0] phase_div_last    = 4'(phase_div_cycles - 1);
    localparam logic [3:0] decade_last       = 4'h9;
    localparam int         decade_stages     = 4;

    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage : interval_timer_pkg

//--- logic/decade_divider.sv
// Four-stage decade divider chain producing one-cycle tick enables
`timescale 1ns/100ps
module decade_divider
    import interval_timer_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       phase_tick,
    output logic      [3:0] decade_tick
);

    logic [3:0] digit_reg [decade_stages];
    logic [4:0] carry;

    assign carry[0] = phase_tick;

    // ==========================================================
    // Ripple of divide-by-ten stages
    genvar g;
    generate
        for (g = 0; g < decade_stages; g++) begin : g_stage
            assign carry[g+1]     = carry[g] && (digit_reg[g] == decade_last);
            assign decade_tick[g] = carry[g+1];
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    digit_reg[g] <= 4'h0;
                end else if (carry[g]) begin
                    digit_reg[g] <= (digit_reg[g] == decade_last) ? 4'h0 : digit_reg[g] + 4'h1;
                end
            end
        end
    endgenerate

    chk_decade_ratio: assert property (@(posedge clock) disable iff (sys_rst)
        decade_tick[0] |=> digit_reg[0] == 4'h0)
        else $error("decade digit did not wrap");

endmodule : decade_divider

//--- logic/rate_selector.sv
// Eight-way clock selector with disable gate
`timescale 1ns/100ps
module rate_selector
    import interval_timer_pkg::*;
(
    input  wire logic [3:0] rate_select,
    input  wire logic       phase_tick,
    input  wire logic [3:0] decade_tick,
    output logic            count_tick
);

    function automatic logic pick(input logic [2:0] code, input logic ph, input logic [3:0] dec);
        logic r;
        r = 1'b0;
        unique case (code)
            rate_100hz:  r = dec[3];
            rate_1khz:   r = dec[2];
            rate_10khz:  r = dec[1];
            rate_100khz: r = dec[0];
            rate_1mhz:   r = ph;
            default:     r = 1'b0;
        endcase
        return r;
    endfunction : pick

    assign count_tick = !rate_select[disable_bit] && pick(rate_select[2:0], phase_tick, decade_tick);

endmodule : rate_selector

//--- logic/programmable_interval_timer.sv
// Programmable interval timer: AXI4-Lite registers, divider, selector, down counter
`timescale 1ns/100ps
module programmable_interval_timer
    import interval_timer_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             zero_reached_n,
    output logic             irq
);

    logic [3:0]  rate_output_latch_reg;
    logic [7:0]  count_output_latch_reg;
    logic [7:0]  count_reg;
    logic        count_load_strobe_n;
    logic [1:0]  irq_status_reg;
    logic [1:0]  irq_mask_reg;
    logic [3:0]  phase_div_reg;
    logic        phase_tick;
    logic [3:0]  decade_tick;
    logic        count_tick;
    logic        zero_reg;
    logic        aw_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_hold_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        do_write;
    logic        do_read;
    logic        status_read;
    logic        zero_event;

    // ==========================================================
    // Write channel: address and data latched in either order
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    assign do_write      = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    function automatic logic mapped(input logic [7:0] a);
        return a == rate_select_addr || a == preset_count_addr || a == count_status_addr ||
               a == irq_status_addr || a == irq_mask_addr;
    endfunction : mapped

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_reg) ? resp_okay : resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rate_output_latch_reg <= rate_select_reset;
            irq_mask_reg          <= irq_mask_reset;
        end else if (do_write && w_strb_reg[0]) begin
            if (aw_addr_reg == rate_select_addr) begin
                rate_output_latch_reg <= w_data_reg[3:0];
            end
            if (aw_addr_reg == irq_mask_addr) begin
                irq_mask_reg <= w_data_reg[1:0];
            end
        end
    end

    // count latch and load strobe on each count write with byte lane 0 strobed
    assign count_load_strobe_n = !(do_write && w_strb_reg[0] && aw_addr_reg == preset_count_addr);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_output_latch_reg <= preset_count_reset;
        end else if (!count_load_strobe_n) begin
            count_output_latch_reg <= w_data_reg[7:0];
        end
    end

    // ==========================================================
    // Phase clock enable, 1 MHz from the 10 MHz clock
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_div_reg <= 4'h0;
        end else begin
            phase_div_reg <= (phase_div_reg == phase_div_last) ? 4'h0 : phase_div_reg + 4'h1;
        end
    end
    assign phase_tick = (phase_div_reg == phase_div_last);

    decade_divider u_divider (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .phase_tick  (phase_tick),
        .decade_tick (decade_tick)
    );

    rate_selector u_selector (
        .rate_select (rate_output_latch_reg),
        .phase_tick  (phase_tick),
        .decade_tick (decade_tick),
        .count_tick  (count_tick)
    );

    // ==========================================================
    // Down counter
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= 8'h00;
        end else if (!count_load_strobe_n) begin
            count_reg <= w_data_reg[7:0];
        end else if (count_tick && count_reg != 8'h00) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    // Registered so the zero output stays glitch free; a preset of zero flags at once.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            zero_reg <= 1'b0;
        end else begin
            zero_reg <= (count_reg == 8'h00) && count_load_strobe_n;
        end
    end
    assign zero_reached_n = !zero_reg;
    assign zero_event     = (count_reg == 8'h00) && count_load_strobe_n && !zero_reg;

    // ==========================================================
    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read       = s_axi_arvalid && s_axi_arready;
    assign status_read   = do_read && s_axi_araddr == irq_status_addr;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= resp_okay;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? resp_okay : resp_slverr;
            unique case (s_axi_araddr)
                rate_select_addr:  s_axi_rdata <= {28'h0, rate_output_latch_reg};
                preset_count_addr: s_axi_rdata <= {24'h0, count_output_latch_reg};
                count_status_addr: s_axi_rdata <= {23'h0, zero_reg, count_reg};
                irq_status_addr:   s_axi_rdata <= {30'h0, irq_status_reg};
                irq_mask_addr:     s_axi_rdata <= {30'h0, irq_mask_reg};
                default:           s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Sticky events, cleared by status read; a new event wins over the clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg[irq_zero_bit] <= zero_event || (irq_status_reg[irq_zero_bit] && !status_read);
            irq_status_reg[irq_load_bit] <= !count_load_strobe_n ||
                                            (irq_status_reg[irq_load_bit] && !status_read);
        end
    end
    assign irq = |(irq_status_reg & irq_mask_reg);

    // ==========================================================
    // Checks
    // preset on load
    chk_load_presets: assert property (@(posedge clock) disable iff (sys_rst)
        !count_load_strobe_n |=> count_reg == $past(w_data_reg[7:0]))
        else $error("count not preset by load");

    chk_count_step: assert property (@(posedge clock) disable iff (sys_rst)
        count_load_strobe_n && count_tick && count_reg != 8'h00 |=> count_reg == $past(count_reg) - 8'h01)
        else $error("count did not decrement");

    chk_hold_still: assert property (@(posedge clock) disable iff (sys_rst)
        count_load_strobe_n && !count_tick |=> $stable(count_reg))
        else $error("count moved without tick");

    chk_zero_low: assert property (@(posedge clock) disable iff (sys_rst)
        count_load_strobe_n && count_reg == 8'h00 |=> !zero_reached_n)
        else $error("zero output not low at zero");

    chk_zero_holds: assert property (@(posedge clock) disable iff (sys_rst)
        !zero_reached_n && count_load_strobe_n |=> !zero_reached_n && count_reg == 8'h00)
        else $error("zero released without load");

    chk_disable_gate: assert property (@(posedge clock) disable iff (sys_rst)
        rate_output_latch_reg[disable_bit] |-> !count_tick)
        else $error("tick while disabled");

    chk_grounded_code: assert property (@(posedge clock) disable iff (sys_rst)
        rate_output_latch_reg[2:0] == 3'h0 || rate_output_latch_reg[2:0] > rate_1mhz |-> !count_tick)
        else $error("tick on grounded code");

    chk_fast_rate: assert property (@(posedge clock) disable iff (sys_rst)
        rate_output_latch_reg == {1'b0, rate_1mhz} |-> count_tick == phase_tick)
        else $error("1 MHz code not undivided");

    chk_slow_rate: assert property (@(posedge clock) disable iff (sys_rst)
        rate_output_latch_reg == {1'b0, rate_100hz} |-> count_tick == decade_tick[3])
        else $error("100 Hz code wrong input");

    chk_count_lsb: assert property (@(posedge clock) disable iff (sys_rst)
        !count_load_strobe_n |=> count_output_latch_reg[0] == $past(w_data_reg[0]))
        else $error("count bit order wrong");

    chk_zero_event: assert property (@(posedge clock) disable iff (sys_rst)
        zero_event |=> irq_status_reg[irq_zero_bit])
        else $error("zero event lost");

    chk_load_event: assert property (@(posedge clock) disable iff (sys_rst)
        !count_load_strobe_n |=> irq_status_reg[irq_load_bit])
        else $error("load event lost");

    chk_zero_release: assert property (@(posedge clock) disable iff (sys_rst)
        !count_load_strobe_n && w_data_reg[7:0] != 8'h00 |=> zero_reached_n)
        else $error("zero output not released by load");

    // phase enable every ten clocks; counts follow the 10 MHz to 1 MHz ratio
    chk_phase_spacing: assert property (@(posedge clock) disable iff (sys_rst)
        phase_tick |=> (!phase_tick) [*8] ##1 !phase_tick ##1 phase_tick)
        else $error("phase tick spacing wrong");

    chk_hundred_khz: assert property (@(posedge clock) disable iff (sys_rst)
        rate_output_latch_reg == {1'b0, rate_100khz} |-> count_tick == decade_tick[0])
        else $error("100 kHz code wrong input");

    chk_ten_khz: assert property (@(posedge clock) disable iff (sys_rst)
        rate_output_latch_reg == {1'b0, rate_10khz} |-> count_tick == decade_tick[1])
        else $error("10 kHz code wrong input");

    chk_one_khz: assert property (@(posedge clock) disable iff (sys_rst)
        rate_output_latch_reg == {1'b0, rate_1khz} |-> count_tick == decade_tick[2])
        else $error("1 kHz code wrong input");

endmodule : programmable_interval_timer

//--- verification/host_port_model.sv
// Host port model: watches the zero output and counts interrupt edges
`timescale 1ns/100ps
module host_port_model (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic port_irq_input,
    output int        falls
);
    logic last_reg;
    // ==========================================
    // Edge detect
    // falling edge raises interrupt
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            last_reg <= 1'b1;
            falls    <= 0;
        end else begin
            last_reg <= port_irq_input;
            if (last_reg && !port_irq_input) begin
                falls <= falls + 1;
            end
        end
    end
endmodule : host_port_model

//--- verification/tb_top.sv
// Self-checking testbench for the programmable interval timer
`timescale 1ns/100ps
module tb_top;
    import interval_timer_pkg::*;
    logic        clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, zero_reached_n, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [2:0]  stop_codes [3] = '{3'h0, 3'h6, 3'h7};
    logic [2:0]  run_codes [4] = '{rate_1mhz, rate_100khz, rate_10khz, rate_1khz};
    int          num_errors, n_compared, falls, exp_falls;

    programmable_interval_timer uut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .zero_reached_n, .irq);
    host_port_model host (.clock, .sys_rst, .port_irq_input(zero_reached_n), .falls);

    // ==========================================
    // Helpers
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    function logic [31:0] status_of(input logic [7:0] c);
        return {23'h0, c == 8'h00, c};
    endfunction : status_of
    // Handshakes judged at the falling edge, where inputs are settled
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic pa, pw, ah, wh, hit;
        int   k;
        // An edge between transfers, so no signal is driven twice in one step
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        hit = 1'b0;
        k = 0;
        while (!hit) begin
            @(negedge clock);
            hit = !pa && !pw && s_axi_bvalid === 1'b1;
            ah = pa && s_axi_awready;
            wh = pw && s_axi_wready;
            resp = s_axi_bresp;
            @(posedge clock);
            pa = pa && !ah;
            pw = pw && !wh;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
            k++;
        end
        s_axi_bready <= 1'b0;
        check("write answer cycles", 32'(k), 32'h3);
    endtask : axi_wr
    task axi_rd(input logic [7:0] a);
        logic pa, ah, hit;
        int   k;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        pa = 1'b1;
        hit = 1'b0;
        k = 0;
        while (!hit) begin
            @(negedge clock);
            hit = !pa && s_axi_rvalid === 1'b1;
            ah = pa && s_axi_arready;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clock);
            pa = pa && !ah;
            s_axi_arvalid <= pa;
            k++;
        end
        s_axi_rready <= 1'b0;
        check("read answer cycles", 32'(k), 32'h2);
    endtask : axi_rd
    task rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        axi_rd(a);
        check(what, rd, exp);
    endtask : rd_check
    task load(input logic [3:0] code, input logic [7:0] n);
        axi_wr(rate_select_addr, {28'h0, code}, 4'hF);
        axi_wr(preset_count_addr, {24'h0, n}, 4'hF);
    endtask : load
    task wait_zero(input int lo, input int hi);
        int k;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (zero_reached_n !== 1'b0 && k <= hi);
        @(posedge clock);
        check("cycles to zero in window", 32'(k >= lo && k <= hi), 32'h1);
        exp_falls++;
    endtask : wait_zero
    // Pin is read after the edge, so the settled value is judged
    task see(input string what, input logic pick_irq, input logic exp);
        @(negedge clock);
        check(what, 32'(pick_irq ? irq : zero_reached_n), 32'(exp));
        @(posedge clock);
    endtask : see
    task close_out();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // ==========================================
    // Clock, watchdog
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Run needs about 37k cycles worst case
    initial begin
        #6_000_000;
        num_errors++;
        close_out();
    end

    // ==========================================
    // Scenarios
    initial begin
        int n, c;
        seed = 32'd98886;
        exp_falls = 1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        sys_rst = 1'b1;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd_check(rate_select_addr, 32'h0, "rate after reset");
        check("mapped read resp", 32'(resp), 32'(resp_okay));
        rd_check(irq_mask_addr, 32'h0, "mask after reset");
        rd_check(count_status_addr, status_of(8'h00), "status after reset");
        rd_check(8'h14, 32'h0, "unmapped read data");
        check("unmapped read resp", 32'(resp), 32'(resp_slverr));
        axi_wr(8'h18, 32'hFFFFFFFF, 4'hF);
        check("unmapped write resp", 32'(resp), 32'(resp_slverr));
        axi_rd(irq_status_addr);
        for (int i = 0; i < 3; i++) begin
            load({1'b0, stop_codes[i]}, 8'h05);
            repeat (150) @(posedge clock);
            rd_check(count_status_addr, status_of(8'h05), "grounded code holds count");
            see("zero output idle", 1'b0, 1'b1);
        end
        // Low strobe lane clear: no load
        axi_wr(preset_count_addr, 32'h9, 4'hE);
        rd_check(count_status_addr, status_of(8'h05), "masked strobe ignored");
        load({1'b0, rate_1mhz}, 8'hC8);
        repeat (100) @(posedge clock);
        axi_wr(rate_select_addr, 32'hD, 4'hF);
        rd_check(rate_select_addr, 32'hD, "rate readback");
        axi_rd(count_status_addr);
        c = int'(rd[7:0]);
        check("count moved before gate", 32'(c < 8'hC8 && c > 0), 32'h1);
        repeat (100) @(posedge clock);
        rd_check(count_status_addr, status_of(8'(c)), "gated count frozen");
        axi_wr(rate_select_addr, {29'h0, rate_1mhz}, 4'hF);
        wait_zero((c - 1) * 10 - 5, c * 10 + 20);
        for (int i = 0; i < 4; i++) begin
            n = int'(xorshift() % 3) + 1;
            c = phase_div_cycles * (10 ** i);
            load({1'b0, run_codes[i]}, 8'(n));
            wait_zero((n - 1) * c - 3, n * c + 6);
        end
        repeat (50) @(posedge clock);
        rd_check(count_status_addr, status_of(8'h00), "held at zero");
        see("zero output held low", 1'b0, 1'b0);
        // Slowest code: must not expire quickly
        load({1'b0, rate_100hz}, 8'h02);
        repeat (200) @(posedge clock);
        see("slow code not expired", 1'b0, 1'b1);
        axi_rd(irq_status_addr);
        axi_wr(irq_mask_addr, 32'h3, 4'hF);
        check("mapped write resp", 32'(resp), 32'(resp_okay));
        load({1'b0, rate_1mhz}, 8'h02);
        see("irq on load done", 1'b1, 1'b1);
        rd_check(irq_status_addr, 32'h2, "load event sticky");
        see("irq cleared by read", 1'b1, 1'b0);
        wait_zero(0, 40);
        see("irq on zero", 1'b1, 1'b1);
        rd_check(irq_status_addr, 32'h1, "zero event sticky");
        axi_wr(irq_mask_addr, 32'h0, 4'hF);
        load({1'b0, rate_1mhz}, 8'h01);
        wait_zero(0, 20);
        see("masked irq low", 1'b1, 1'b0);
        rd_check(irq_status_addr, 32'h3, "masked events kept");
        check("host interrupt count", 32'(falls), 32'(exp_falls));
        load({1'b0, rate_1mhz}, 8'h00);
        repeat (3) @(posedge clock);
        see("preset zero expires", 1'b0, 1'b0);
        close_out();
    end
endmodule : tb_top
